// *** rtl/bfr_pkg.sv ***
/*
 * Constants, register map and classification codes for the broadcast
 * frame relay filter. Assumes a 32-bit APB slave with byte addresses.
 */
package bfr_pkg;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFF      = 12'h000;
    localparam logic [11:0] NODE_ID_OFF   = 12'h004;
    localparam logic [11:0] MAC_LO_OFF    = 12'h008;
    localparam logic [11:0] MAC_HI_OFF    = 12'h00C;
    localparam logic [11:0] BRANCH_OFF    = 12'h010;
    localparam logic [11:0] STATUS_OFF    = 12'h014;
    localparam logic [11:0] FRAME_CNT_OFF = 12'h018;
    localparam logic [11:0] DROP_CNT_OFF  = 12'h01C;
    localparam logic [11:0] LOCAL_ATTACHED_ADDRESS_TABLE_BASE     = 12'h040;
    localparam logic [11:0] REMOTE_ATTACHED_ADDRESS_TABLE_BASE     = 12'h080;
    localparam logic [11:0] TABLE_SPAN    = 12'h020;

    // Attached address tables
    localparam int unsigned TABLE_DEPTH     = 4;
    localparam int unsigned ENTRY_VALID_BIT = 31;

    // Control fields
    localparam int unsigned CTRL_EN_BIT         = 0;
    localparam int unsigned CTRL_OWN_RELAY_BIT  = 1;
    localparam int unsigned CTRL_LOCAL_ATTACHED_ADDRESS_TABLE_RELAY_BIT = 2;
    localparam int unsigned CTRL_REMOTE_ATTACHED_ADDRESS_TABLE_HOST_BIT  = 3;

    // Values after reset
    localparam logic [3:0]  CTRL_RST    = 4'h1;
    localparam logic [7:0]  NODE_ID_RST = 8'h00;
    localparam logic [47:0] MAC_RST     = 48'h000000000000;
    localparam logic [7:0]  BRANCH_RST  = 8'h00;

    // Protocol values
    localparam logic [7:0]  ALL_NODES_ID = 8'hFF;
    localparam logic [47:0] BCAST_MAC    = 48'hFFFFFFFFFFFF;
    localparam logic [47:0] MGMT_MAC     = 48'h0119A7527696;

    // Status fields
    localparam int unsigned STAT_ACT_LSB   = 0;
    localparam int unsigned STAT_CLASS_LSB = 8;
    localparam int unsigned STAT_LEAF_BIT  = 16;

    // Destination MAC class, highest priority first
    typedef enum logic [5:0] {
        CL_OWN   = 6'h01,
        CL_BCAST = 6'h02,
        CL_MGMT  = 6'h04,
        CL_LOCAL_ATTACHED_ADDRESS_TABLE  = 6'h08,
        CL_REMOTE_ATTACHED_ADDRESS_TABLE  = 6'h10,
        CL_OTHER = 6'h20
    } bfr_class_e;

endpackage : bfr_pkg

// *** rtl/bfr_filter.sv ***
/*
 * Receive-side broadcast decision logic with its APB register file.
 * Assumes frames come from same-clock logic that has already run the
 * relay table filtering and flags its result on in_filter_drop.
 */
`timescale 1ns/1ns
`default_nettype none

module bfr_filter (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Incoming frame descriptor
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic        in_bcast_bit,
    input  wire logic        in_mcast_bit,
    input  wire logic        in_is_link_control_data_unit,
    input  wire logic [7:0]  in_dest_node,
    input  wire logic [47:0] in_dest_mac,
    input  wire logic        in_filter_drop,
    input  wire logic [7:0]  in_tag,
    // Decision
    output logic             dec_valid,
    input  wire logic        dec_ready,
    output logic             dec_mgmt,
    output logic             dec_host,
    output logic             dec_relay,
    output logic             dec_unicast,
    output logic             dec_drop,
    output logic [7:0]       dec_tag
);

    ////////////////////////////////////////////////////////////////////
    // Register state

    logic [3:0]  ctrl_reg;
    logic [7:0]  node_id_reg;
    logic [47:0] mac_reg;
    logic [7:0]  branch_reg;
    logic [31:0] frame_cnt_reg;
    logic [31:0] drop_cnt_reg;
    logic [5:0]  last_class_reg;
    logic [4:0]  last_act_reg;
    logic [47:0] local_attached_address_table_mac [0:bfr_pkg::TABLE_DEPTH-1];
    logic        local_attached_address_table_vld [0:bfr_pkg::TABLE_DEPTH-1];
    logic [47:0] remote_attached_address_table_mac [0:bfr_pkg::TABLE_DEPTH-1];
    logic        remote_attached_address_table_vld [0:bfr_pkg::TABLE_DEPTH-1];

    logic        dec_valid_reg;
    logic        dec_mgmt_reg;
    logic        dec_host_reg;
    logic        dec_relay_reg;
    logic        dec_unicast_reg;
    logic        dec_drop_reg;
    logic [7:0]  dec_tag_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    ////////////////////////////////////////////////////////////////////
    // APB decode

    logic        setup_ph;
    logic        wr_en;
    logic        in_local_attached_address_table;
    logic        in_remote_attached_address_table;
    logic [1:0]  tbl_idx;
    logic        tbl_hi;
    logic        mapped;
    logic [31:0] rd_mux;
    logic        leaf;

    assign setup_ph = psel && !penable;
    assign pready   = psel && penable;
    assign wr_en    = psel && penable && pwrite && !pslverr_reg;
    assign in_local_attached_address_table  = paddr >= bfr_pkg::LOCAL_ATTACHED_ADDRESS_TABLE_BASE &&
                      paddr < bfr_pkg::LOCAL_ATTACHED_ADDRESS_TABLE_BASE + bfr_pkg::TABLE_SPAN;
    assign in_remote_attached_address_table  = paddr >= bfr_pkg::REMOTE_ATTACHED_ADDRESS_TABLE_BASE &&
                      paddr < bfr_pkg::REMOTE_ATTACHED_ADDRESS_TABLE_BASE + bfr_pkg::TABLE_SPAN;
    assign tbl_idx  = paddr[4:3];
    assign tbl_hi   = paddr[2];
    assign leaf     = branch_reg == 8'h00;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (in_local_attached_address_table) begin
            rd_mux = tbl_hi ? {local_attached_address_table_vld[tbl_idx], 15'h0000,
                               local_attached_address_table_mac[tbl_idx][47:32]}
                            : local_attached_address_table_mac[tbl_idx][31:0];
        end else if (in_remote_attached_address_table) begin
            rd_mux = tbl_hi ? {remote_attached_address_table_vld[tbl_idx], 15'h0000,
                               remote_attached_address_table_mac[tbl_idx][47:32]}
                            : remote_attached_address_table_mac[tbl_idx][31:0];
        end else begin
            case (paddr)
                bfr_pkg::CTRL_OFF:      rd_mux = {28'h0000000, ctrl_reg};
                bfr_pkg::NODE_ID_OFF:   rd_mux = {24'h000000, node_id_reg};
                bfr_pkg::MAC_LO_OFF:    rd_mux = mac_reg[31:0];
                bfr_pkg::MAC_HI_OFF:    rd_mux = {16'h0000, mac_reg[47:32]};
                bfr_pkg::BRANCH_OFF:    rd_mux = {24'h000000, branch_reg};
                bfr_pkg::STATUS_OFF:    rd_mux = {15'h0000, leaf,
                                                  2'h0, last_class_reg,
                                                  3'h0, last_act_reg};
                bfr_pkg::FRAME_CNT_OFF: rd_mux = frame_cnt_reg;
                bfr_pkg::DROP_CNT_OFF:  rd_mux = drop_cnt_reg;
                default:                mapped = 1'b0;
            endcase
        end
    end

    // Read data and error are caught in setup so both come from flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_reg <= !mapped;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && pready;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg    <= bfr_pkg::CTRL_RST;
            node_id_reg <= bfr_pkg::NODE_ID_RST;
            mac_reg     <= bfr_pkg::MAC_RST;
            branch_reg  <= bfr_pkg::BRANCH_RST;
        end else if (wr_en) begin
            case (paddr)
                bfr_pkg::CTRL_OFF:    ctrl_reg           <= pwdata[3:0];
                bfr_pkg::NODE_ID_OFF: node_id_reg        <= pwdata[7:0];
                bfr_pkg::MAC_LO_OFF:  mac_reg[31:0]      <= pwdata;
                bfr_pkg::MAC_HI_OFF:  mac_reg[47:32]     <= pwdata[15:0];
                bfr_pkg::BRANCH_OFF:  branch_reg         <= pwdata[7:0];
                default:              ctrl_reg           <= ctrl_reg;
            endcase
        end
    end

    // Tables; an entry matches only while its valid bit is set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < bfr_pkg::TABLE_DEPTH; i++) begin
                local_attached_address_table_mac[i] <= bfr_pkg::MAC_RST;
                local_attached_address_table_vld[i] <= 1'b0;
                remote_attached_address_table_mac[i] <= bfr_pkg::MAC_RST;
                remote_attached_address_table_vld[i] <= 1'b0;
            end
        end else if (wr_en && in_local_attached_address_table) begin
            if (tbl_hi) begin
                local_attached_address_table_mac[tbl_idx][47:32] <= pwdata[15:0];
                local_attached_address_table_vld[tbl_idx] <= pwdata[bfr_pkg::ENTRY_VALID_BIT];
            end else begin
                local_attached_address_table_mac[tbl_idx][31:0] <= pwdata;
            end
        end else if (wr_en && in_remote_attached_address_table) begin
            if (tbl_hi) begin
                remote_attached_address_table_mac[tbl_idx][47:32] <= pwdata[15:0];
                remote_attached_address_table_vld[tbl_idx] <= pwdata[bfr_pkg::ENTRY_VALID_BIT];
            end else begin
                remote_attached_address_table_mac[tbl_idx][31:0] <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Classification

    logic               hit_local_attached_address_table;
    logic               hit_remote_attached_address_table;
    bfr_pkg::bfr_class_e cls;

    always_comb begin
        hit_local_attached_address_table = 1'b0;
        hit_remote_attached_address_table = 1'b0;
        for (int i = 0; i < bfr_pkg::TABLE_DEPTH; i++) begin
            if (local_attached_address_table_vld[i] && local_attached_address_table_mac[i] == in_dest_mac) begin
                hit_local_attached_address_table = 1'b1;
            end
            if (remote_attached_address_table_vld[i] && remote_attached_address_table_mac[i] == in_dest_mac) begin
                hit_remote_attached_address_table = 1'b1;
            end
        end
    end

    // Own address wins so a table entry for it never hides it
    always_comb begin
        if (in_dest_mac == mac_reg) begin
            cls = bfr_pkg::CL_OWN;
        end else if (in_dest_mac == bfr_pkg::BCAST_MAC) begin
            cls = bfr_pkg::CL_BCAST;
        end else if (in_dest_mac == bfr_pkg::MGMT_MAC) begin
            cls = bfr_pkg::CL_MGMT;
        end else if (hit_local_attached_address_table) begin
            cls = bfr_pkg::CL_LOCAL_ATTACHED_ADDRESS_TABLE;
        end else if (hit_remote_attached_address_table) begin
            cls = bfr_pkg::CL_REMOTE_ATTACHED_ADDRESS_TABLE;
        end else begin
            cls = bfr_pkg::CL_OTHER;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decision table

    logic opt_own;
    logic opt_local_attached_address_table;
    logic opt_remote_attached_address_table;
    logic n_mgmt;
    logic n_host;
    logic n_relay;
    logic n_uni;
    logic accept;

    assign opt_own  = ctrl_reg[bfr_pkg::CTRL_OWN_RELAY_BIT];
    assign opt_local_attached_address_table = ctrl_reg[bfr_pkg::CTRL_LOCAL_ATTACHED_ADDRESS_TABLE_RELAY_BIT];
    assign opt_remote_attached_address_table = ctrl_reg[bfr_pkg::CTRL_REMOTE_ATTACHED_ADDRESS_TABLE_HOST_BIT];
    assign in_ready = ctrl_reg[bfr_pkg::CTRL_EN_BIT] &&
                      (!dec_valid_reg || dec_ready);
    assign accept   = in_valid && in_ready;

    always_comb begin
        n_mgmt  = 1'b0;
        n_host  = 1'b0;
        n_relay = 1'b0;
        n_uni   = 1'b0;
        if (in_filter_drop) begin
            n_uni = 1'b0;
        end else if (!in_bcast_bit) begin
            n_uni = 1'b1;
        end else if (in_dest_node == node_id_reg) begin
            n_uni = 1'b1;
        end else if (in_dest_node != bfr_pkg::ALL_NODES_ID) begin
            n_relay = !leaf;
        end else if (in_is_link_control_data_unit) begin
            case (cls)
                bfr_pkg::CL_OWN: begin
                    n_mgmt  = 1'b1;
                    n_relay = !leaf && opt_own;
                end
                bfr_pkg::CL_BCAST, bfr_pkg::CL_MGMT: begin
                    n_mgmt  = 1'b1;
                    n_relay = !leaf;
                end
                default: begin
                    n_relay = !leaf;
                end
            endcase
        end else begin
            case (cls)
                bfr_pkg::CL_OWN: begin
                    n_mgmt  = 1'b1;
                    n_relay = !leaf && opt_own;
                end
                bfr_pkg::CL_MGMT: begin
                    n_mgmt  = 1'b1;
                    n_relay = !leaf;
                end
                bfr_pkg::CL_BCAST: begin
                    n_mgmt  = 1'b1;
                    n_host  = 1'b1;
                    n_relay = !leaf;
                end
                bfr_pkg::CL_LOCAL_ATTACHED_ADDRESS_TABLE: begin
                    n_host  = 1'b1;
                    n_relay = !leaf && opt_local_attached_address_table;
                end
                bfr_pkg::CL_REMOTE_ATTACHED_ADDRESS_TABLE: begin
                    n_host  = opt_remote_attached_address_table;
                    n_relay = !leaf;
                end
                default: begin
                    n_host  = 1'b1;
                    n_relay = !leaf;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid_reg   <= 1'b0;
            dec_mgmt_reg    <= 1'b0;
            dec_host_reg    <= 1'b0;
            dec_relay_reg   <= 1'b0;
            dec_unicast_reg <= 1'b0;
            dec_drop_reg    <= 1'b0;
            dec_tag_reg     <= 8'h00;
        end else if (accept) begin
            dec_valid_reg   <= 1'b1;
            dec_mgmt_reg    <= n_mgmt;
            dec_host_reg    <= n_host;
            dec_relay_reg   <= n_relay;
            dec_unicast_reg <= n_uni;
            dec_drop_reg    <= !(n_mgmt || n_host || n_relay || n_uni);
            dec_tag_reg     <= in_tag;
        end else if (dec_ready) begin
            dec_valid_reg   <= 1'b0;
        end
    end

    assign dec_valid   = dec_valid_reg;
    assign dec_mgmt    = dec_mgmt_reg;
    assign dec_host    = dec_host_reg;
    assign dec_relay   = dec_relay_reg;
    assign dec_unicast = dec_unicast_reg;
    assign dec_drop    = dec_drop_reg;
    assign dec_tag     = dec_tag_reg;

    // Counters wrap silently; software reads the difference
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt_reg  <= 32'h00000000;
            drop_cnt_reg   <= 32'h00000000;
            last_class_reg <= 6'h00;
            last_act_reg   <= 5'h00;
        end else if (accept) begin
            frame_cnt_reg  <= frame_cnt_reg + 32'h00000001;
            last_class_reg <= cls;
            last_act_reg   <= {n_uni, n_relay, n_host, n_mgmt,
                               !(n_mgmt || n_host || n_relay || n_uni)};
            if (!(n_mgmt || n_host || n_relay || n_uni)) begin
                drop_cnt_reg <= drop_cnt_reg + 32'h00000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic bc_ok;
    assign bc_ok = accept && in_bcast_bit && !in_filter_drop;

    own_node_a: assert property (
        bc_ok && in_dest_node == node_id_reg
        |=> dec_valid && dec_unicast && !dec_relay && !dec_host)
        else $error("own node frame not sent to unicast");

    leaf_mgmt_a: assert property (
        bc_ok && leaf && !in_is_link_control_data_unit &&
        in_dest_node == bfr_pkg::ALL_NODES_ID &&
        in_dest_node != node_id_reg && in_dest_mac == bfr_pkg::MGMT_MAC &&
        in_dest_mac != mac_reg
        |=> dec_mgmt && !dec_relay && !dec_host)
        else $error("leaf management frame misrouted");

    leaf_bcast_a: assert property (
        bc_ok && leaf && !in_is_link_control_data_unit &&
        in_dest_node == bfr_pkg::ALL_NODES_ID &&
        in_dest_node != node_id_reg && in_dest_mac == bfr_pkg::BCAST_MAC &&
        in_dest_mac != mac_reg
        |=> dec_mgmt && dec_host && !dec_relay)
        else $error("leaf broadcast frame misrouted");

    leaf_norelay_a: assert property (
        dec_valid && leaf |-> !dec_relay)
        else $error("leaf node relayed a frame");

    nonleaf_mgmt_a: assert property (
        bc_ok && !leaf && in_dest_node == bfr_pkg::ALL_NODES_ID &&
        in_dest_node != node_id_reg && in_dest_mac == bfr_pkg::MGMT_MAC &&
        in_dest_mac != mac_reg
        |=> dec_mgmt && dec_relay && !dec_unicast)
        else $error("non-leaf management frame misrouted");

    nonleaf_bcast_a: assert property (
        bc_ok && !leaf && !in_is_link_control_data_unit &&
        in_dest_node == bfr_pkg::ALL_NODES_ID &&
        in_dest_node != node_id_reg && in_dest_mac == bfr_pkg::BCAST_MAC &&
        in_dest_mac != mac_reg
        |=> dec_mgmt && dec_host && dec_relay)
        else $error("non-leaf broadcast frame misrouted");

    other_node_a: assert property (
        bc_ok && in_dest_node != bfr_pkg::ALL_NODES_ID &&
        in_dest_node != node_id_reg
        |=> dec_relay == !$past(leaf) && dec_drop == $past(leaf))
        else $error("frame for other node misrouted");

    link_control_data_unit_host_a: assert property (
        dec_valid && $past(accept && in_is_link_control_data_unit && in_bcast_bit)
        |-> !dec_host)
        else $error("control unit passed to host port");

    filter_drop_a: assert property (
        accept && in_filter_drop |=> dec_valid && dec_drop &&
        !dec_mgmt && !dec_relay)
        else $error("filtered frame not dropped");

    hold_dec_a: assert property (
        dec_valid && !dec_ready |=> dec_valid && $stable(dec_tag))
        else $error("decision withdrawn before taken");

endmodule : bfr_filter

`default_nettype wire

// *** tb/bfr_peer_src.sv ***
/*
 * Peer node frame source: offers one descriptor at a time and holds it
 * until accepted or 50 edges pass. Assumes in_ready settles well before each edge.
 */
`timescale 1ns/1ns
`default_nettype none

module bfr_peer_src (
    input  wire logic        clock,
    input  wire logic        in_ready,
    output logic             in_valid,
    output logic             in_bcast_bit,
    output logic             in_mcast_bit,
    output logic             in_is_link_control_data_unit,
    output logic [7:0]       in_dest_node,
    output logic [47:0]      in_dest_mac,
    output logic             in_filter_drop,
    output logic [7:0]       in_tag
);
    logic [67:0] f;

    assign {in_bcast_bit, in_mcast_bit, in_is_link_control_data_unit, in_dest_node,
            in_dest_mac, in_filter_drop, in_tag} = f;

    initial begin
        in_valid = 1'b0;
        f = '0;
    end

    task send(input logic [67:0] fi, output logic ok);
        int n;
        @(posedge clock);
        in_valid <= 1'b1;
        f        <= fi;
        n = 0;
        do @(posedge clock); while (in_ready !== 1'b1 && ++n < 50);
        ok = (n < 50);
        in_valid <= 1'b0;
        // Released lines carry garbage, never the last frame
        f        <= ~fi;
    endtask : send
endmodule : bfr_peer_src
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Bench for the broadcast frame filter: APB set-up, frame sweep against
 * a reference model. Assumes zero-wait APB and 1-cycle decisions.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        in_valid, in_ready, in_bcast_bit, in_mcast_bit;
    logic        in_is_link_control_data_unit, in_filter_drop, dec_valid, dec_ready;
    logic [7:0]  in_dest_node, in_tag, dec_tag, nid;
    logic [47:0] in_dest_mac, own_mac, la_mac, ra_mac, oth_mac;
    logic        dec_mgmt, dec_host, dec_relay, dec_unicast, dec_drop;
    logic        er, ok;
    logic [3:0]  ctrl;
    int          error_cnt, n_tests;

    bfr_filter dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .in_valid(in_valid),
        .in_ready(in_ready), .in_bcast_bit(in_bcast_bit),
        .in_mcast_bit(in_mcast_bit), .in_is_link_control_data_unit(in_is_link_control_data_unit),
        .in_dest_node(in_dest_node), .in_dest_mac(in_dest_mac),
        .in_filter_drop(in_filter_drop), .in_tag(in_tag),
        .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_mgmt(dec_mgmt),
        .dec_host(dec_host), .dec_relay(dec_relay),
        .dec_unicast(dec_unicast), .dec_drop(dec_drop), .dec_tag(dec_tag));

    bfr_peer_src src (
        .clock(clock), .in_ready(in_ready), .in_valid(in_valid),
        .in_bcast_bit(in_bcast_bit), .in_mcast_bit(in_mcast_bit),
        .in_is_link_control_data_unit(in_is_link_control_data_unit), .in_dest_node(in_dest_node),
        .in_dest_mac(in_dest_mac), .in_filter_drop(in_filter_drop),
        .in_tag(in_tag));

    always #5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("errors %0d tests %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    task check(input logic c, input string msg);
        n_tests++;
        if (c !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check

    // Read data taken at the very edge that samples pready high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Result bits: 0 management, 1 host, 2 relay, 3 unicast
    function automatic int model(int leaf, int lc, int c, logic [3:0] t);
        if (c == 9) return 0;
        if (c == 8 || c == 6) return 8;
        if (c == 7) return leaf ? 0 : 4;
        if (lc && leaf) return (c < 3) ? 1 : 0;
        if (lc) case (c) 0: return t[1] ? 5 : 1; 1, 2: return 5;
            default: return 4; endcase
        if (leaf) case (c) 0, 2: return 1; 1: return 3;
            4: return t[3] ? 2 : 0; default: return 2; endcase
        case (c) 0: return t[1] ? 5 : 1; 1: return 7; 2: return 5;
            3: return t[2] ? 6 : 2; 4: return t[3] ? 6 : 4;
            default: return 6; endcase
    endfunction : model

    // Classes 0..5 own..other; 6 own node; 7 other node; 8 unicast; 9 drop
    task frame(input int leaf, input int lc, input int c);
        logic [47:0] da;
        logic [7:0]  dn, tg;
        logic        hit;
        int          e;
        da = c == 0 ? own_mac : c == 1 ? bfr_pkg::BCAST_MAC :
             c == 2 ? bfr_pkg::MGMT_MAC : c == 3 ? la_mac :
             c == 4 ? ra_mac : oth_mac;
        dn = c == 6 ? nid : c == 7 ? 8'((nid + 1) % 255) :
             bfr_pkg::ALL_NODES_ID;
        tg = 8'($urandom);
        e = model(leaf, lc, c, ctrl);
        src.send({c != 8, c != 7 && 1'($urandom), 1'(lc), dn, da, c == 9,
                  tg}, ok);
        @(negedge clock);
        hit = ok && dec_valid === 1'b1 && dec_tag === tg &&
              {dec_unicast, dec_relay, dec_host, dec_mgmt} === 4'(e) &&
              dec_drop === (e == 0);
        if (c > 5) check(hit, "node field case");
        else if (lc) check(hit, "control unit");
        else if (leaf) check(hit, "leaf data");
        else check(hit, "relay data");
        @(posedge clock);
        dec_ready <= 1'b1;
        @(negedge clock);
        check(dec_valid === 1'b1, "decision not held");
        @(posedge clock);
        dec_ready <= 1'b0;
        @(negedge clock);
        check(dec_valid === 1'b0, "decision not retired");
    endtask : frame

    ////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        clock = 0;
        rst_n = 0;
        {psel, penable, pwrite, paddr, pwdata, dec_ready} = '0;
        {error_cnt, n_tests, ctrl} = '0;
        void'($urandom(32'h067b5660));
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, bfr_pkg::CTRL_OFF, 32'h0);
        check(rd === 32'h1 && er === 1'b0, "control reset value");
        apb(1'b0, bfr_pkg::NODE_ID_OFF, 32'h0);
        check(rd === 32'h0, "node id reset value");
        apb(1'b1, 12'h100, 32'hFFFFFFFF);
        check(er === 1'b1, "unmapped write accepted");
        nid = 8'($urandom % 255);
        own_mac = 48'({$urandom, $urandom});
        la_mac = 48'({$urandom, $urandom});
        ra_mac = 48'({$urandom, $urandom});
        oth_mac = 48'({$urandom, $urandom});
        apb(1'b1, bfr_pkg::NODE_ID_OFF, {24'h0, nid});
        apb(1'b1, bfr_pkg::MAC_LO_OFF, own_mac[31:0]);
        apb(1'b1, bfr_pkg::MAC_HI_OFF, {16'h0, own_mac[47:32]});
        apb(1'b1, bfr_pkg::LOCAL_ATTACHED_ADDRESS_TABLE_BASE, la_mac[31:0]);
        apb(1'b1, bfr_pkg::LOCAL_ATTACHED_ADDRESS_TABLE_BASE + 12'h4, {16'h8000, la_mac[47:32]});
        // Own MAC also in the local table: priority must pick own
        apb(1'b1, bfr_pkg::LOCAL_ATTACHED_ADDRESS_TABLE_BASE + 12'h8, own_mac[31:0]);
        apb(1'b1, bfr_pkg::LOCAL_ATTACHED_ADDRESS_TABLE_BASE + 12'hC, {16'h8000, own_mac[47:32]});
        apb(1'b1, bfr_pkg::REMOTE_ATTACHED_ADDRESS_TABLE_BASE, ra_mac[31:0]);
        apb(1'b1, bfr_pkg::REMOTE_ATTACHED_ADDRESS_TABLE_BASE + 12'h4, {16'h8000, ra_mac[47:32]});
        for (int leaf = 0; leaf < 2; leaf++) begin
            apb(1'b1, bfr_pkg::BRANCH_OFF,
                leaf ? 32'h0 : 32'(1 + $urandom % 255));
            for (int rep = 0; rep < 2; rep++) begin
                ctrl = {3'($urandom), 1'b1};
                apb(1'b1, bfr_pkg::CTRL_OFF, {28'h0, ctrl});
                for (int lc = 0; lc < 2; lc++)
                    for (int c = 0; c < 10; c++)
                        frame(leaf, lc, c);
            end
            apb(1'b0, bfr_pkg::STATUS_OFF, 32'h0);
            check(rd[16] === 1'(leaf), "leaf status");
        end
        apb(1'b1, bfr_pkg::CTRL_OFF, 32'h0);
        @(negedge clock);
        check(in_ready === 1'b0, "frames taken while disabled");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
